// [rtl/ndc_defines.svh]
// Constants shared by both ends of the direct command link.
`ifndef NDC_DEFINES_SVH
`define NDC_DEFINES_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define NDC_CMD_SET_DEFAULT 8'hc1
`define NDC_CMD_CLEAR_A     8'hc2
`define NDC_CMD_CLEAR_B     8'hc3
`define NDC_CMD_TX_CRC      8'hc4
`define NDC_CMD_TX_WUPA     8'hc7
`define NDC_CMD_FON_INIT    8'hc8
`define NDC_CMD_FON_RESP    8'hc9
`define NDC_CMD_FON_RESP0   8'hca
`define NDC_CMD_GO_NORMAL   8'hcb
`define NDC_CMD_RESET_GAIN  8'hd5
`define NDC_CMD_ADJ_REG     8'hd6
`define NDC_CMD_PHASE       8'hd9
`define NDC_CMD_TEST_CLEAR  8'hfa
`define NDC_CMD_TEST_ACCESS 8'hfc

// ----------------------------------------------------------------------
// Operation control bit positions
// ----------------------------------------------------------------------
`define NDC_OP_EN_BIT    7
`define NDC_OP_RX_EN_BIT 6
`define NDC_OP_TX_EN_BIT 3

// ----------------------------------------------------------------------
// Interrupt flag positions and reset value
// ----------------------------------------------------------------------
`define NDC_IRQ_DONE_BIT 0
`define NDC_IRQ_CAT_BIT  1
`define NDC_IRQ_CAC_BIT  2
`define NDC_IRQ_W        3
`define NDC_IRQ_RESET    3'h0

// ----------------------------------------------------------------------
// Host register offsets and status busy bit
// ----------------------------------------------------------------------
`define NDC_HOST_CMD     2'h0
`define NDC_HOST_CMD_CH  2'h1
`define NDC_HOST_STATUS  2'h2
`define NDC_STAT_BUSY_BIT 3

// ----------------------------------------------------------------------
// Timing: clock and carrier in kHz, times in carrier periods or ms
// ----------------------------------------------------------------------
`define NDC_CLK_KHZ     40000
`define NDC_FC_KHZ      13560
`define NDC_T_IDT_FC    4096
`define NDC_T_RWF_FC    512
`define NDC_T_IRFG_MS   5
`define NDC_T_ADT_FC    768
`define NDC_T_ARFG_FC   1024

`endif

// [rtl/ndc_pkg.sv]
// Types used by the device end of the direct command link.
package ndc_pkg;

  typedef enum logic [1:0] {
    NDC_IDLE     = 2'b00,
    NDC_WAIT_ANA = 2'b01,
    NDC_CA_WATCH = 2'b10,
    NDC_CA_GUARD = 2'b11
  } ndc_state_t;

  typedef enum logic [1:0] {
    NDC_TX_CRC   = 2'b00,
    NDC_TX_NOCRC = 2'b01,
    NDC_TX_REQA  = 2'b10,
    NDC_TX_WUPA  = 2'b11
  } ndc_tx_kind_t;

  typedef enum logic [1:0] {
    NDC_ANA_REG   = 2'b10,
    NDC_ANA_MOD   = 2'b11,
    NDC_ANA_ANT   = 2'b00,
    NDC_ANA_PHASE = 2'b01
  } ndc_ana_t;

endpackage : ndc_pkg

// [rtl/ndc_if.sv]
// Command link between the controller end and the device end.
`timescale 1ns/100ps
interface ndc_if;
  logic       cmd_stb;    // One command byte this cycle.
  logic       cmd_chain;  // Byte continues the previous sequence.
  logic [7:0] cmd_code;   // Command byte.
  logic       busy;       // Device runs a sequence.
  logic       irq;        // Any interrupt flag set.
  logic [2:0] irq_flags;  // Sticky flags: cac, cat, done.
  logic [2:0] irq_ack;    // Flags to clear, one-cycle pulse.

  modport dev  (input cmd_stb, cmd_chain, cmd_code, irq_ack,
                output busy, irq, irq_flags);
  modport host (output cmd_stb, cmd_chain, cmd_code, irq_ack,
                input busy, irq, irq_flags);
endinterface : ndc_if

// [rtl/ndc_timer.sv]
// Loadable down counter that pulses when a loaded wait has run out.
`timescale 1ns/100ps
module ndc_timer #(
  parameter int TW = 18
) (
  input  logic          sys_clk,  // System clock.
  input  logic          rst,      // Synchronous reset.
  input  logic          load,     // Start a wait of load_val cycles.
  input  logic [TW-1:0] load_val, // Wait length, at least one.
  input  logic          stop,     // Abandon the wait.
  output logic          done      // Pulse in the last cycle of the wait.
);
  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;

  assign done     = (cnt_reg == TW'(1)) & ~stop;
  assign cnt_next = stop ? '0 : load ? load_val :
                    (cnt_reg != '0) ? cnt_reg - TW'(1) : cnt_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule : ndc_timer

// [rtl/ndc_device.sv]
// Device end: decodes direct command bytes and runs their actions.
// What this block does
// R1 - Reset-gain drops squelch, loads manual gain
// R2 - Regulator adjust interrupts; refused under external select
// R3 - Modulation calibration runs, then completion interrupt
// R4 - Antenna calibration and phase measure interrupt
// R5 - Test clear only chained right after test access
// R6 - Commands need their operation-control bits set; test access and go-to-normal are taken without the enable bit
// R7 - Set-default resets registers, discards calibration
// R8 - Set-default always taken; FIFO kept without enable; the code refuses it when chained after set-default, reset-gain or analog
// R9 - Clear aborts, empties FIFO, stops timers, clears flags
// R10 - Special-mode bit keeps no-response timer running
// R11 - Auto-response bit keeps response avoidance running
// R12 - Clear needs enable and stable oscillator frequency
// R13 - Controller sends clear, count, data before transmit; the controller end only forwards the bytes software writes
// R14 - Transmit needs transmitter enable; no interrupt
// R15 - Controller zeroes last-byte bits before REQA/WUPA; the controller end forwards bytes unchanged
// R16 - Field-on switches field when none foreign
// R17 - Guard time passes before field-on-done flag
// R18 - Foreign field flags collision, field stays off
// R19 - Slot count from select bits; third uses zero
// R20 - Response active delay at 768 carrier periods
// R21 - Field-on needs enable, stable frequency and amplitude
// R22 - Go-to-normal copies bit rate, sets modulation
// R23 - Unused and reserved codes change nothing
`timescale 1ns/100ps
`include "ndc_defines.svh"
module ndc_device #(
  parameter int TW       = 18,
  parameter int IDT_CYC  = (`NDC_T_IDT_FC * `NDC_CLK_KHZ + `NDC_FC_KHZ - 1) / `NDC_FC_KHZ,
  parameter int IRFG_CYC = `NDC_T_IRFG_MS * `NDC_CLK_KHZ + 1
) (
  input  logic        sys_clk,          // System clock, 40 MHz.
  input  logic        rst,              // Synchronous reset.
  ndc_if.dev          link,             // Command link from the controller.
  input  logic [7:0]  op_ctrl,          // Operation control register.
  input  logic        osc_freq_ok,      // Oscillator frequency stable.
  input  logic        osc_amp_ok,       // Oscillator amplitude stable.
  input  logic        reg_ext_sel,      // External regulated voltage selected.
  input  logic        nrt_special,      // No-response timer special mode.
  input  logic        auto_response_bit, // Response avoidance survives clear.
  input  logic        slot_count_hi,    // Slot count n, high bit.
  input  logic        slot_count_lo,    // Slot count n, low bit.
  input  logic        rf_sense_inputs,  // Foreign field above threshold, pin.
  input  logic        brd_mode,         // Bit-rate detection mode active.
  input  logic [1:0]  brd_rate,         // Detected bit rate.
  input  logic        ana_done,         // Analog sequence finished.
  output logic        gain_reset_stb,   // Drop squelch, load manual gain.
  output logic        ana_start_stb,    // Start analog sequence.
  output ndc_pkg::ndc_ana_t ana_sel,    // Which analog sequence.
  output logic        set_default_stb,  // Reset registers and calibration.
  output logic        fifo_reset_stb,   // Empty FIFO and its status.
  output logic        abort_stb,        // Abort transmission or reception.
  output logic        timers_stop_stb,  // Stop timers but wake-up.
  output logic        nrt_stop_stb,     // Stop no-response timer.
  output logic        tx_start_stb,     // Start a transmission.
  output ndc_pkg::ndc_tx_kind_t tx_kind, // Kind of transmission.
  output logic        field_on_stb,     // Set transmitter enable.
  output logic        leave_brd_stb,    // Leave bit-rate detection.
  output logic [1:0]  bitrate_def,      // Bit rate definition copy.
  output logic        tx_modulation_type_bit, // Modulation type.
  output logic        test_unlock,      // Test registers writable.
  output logic        test_clear_stb    // Clear test registers.
);
  localparam int ADT_CYC  = (`NDC_T_ADT_FC * `NDC_CLK_KHZ + `NDC_FC_KHZ - 1) / `NDC_FC_KHZ;
  localparam int RWF_CYC  = (`NDC_T_RWF_FC * `NDC_CLK_KHZ + `NDC_FC_KHZ - 1) / `NDC_FC_KHZ;
  localparam int ARFG_CYC = (`NDC_T_ARFG_FC * `NDC_CLK_KHZ + `NDC_FC_KHZ - 1) / `NDC_FC_KHZ;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ndc_pkg::ndc_state_t state_reg;
  ndc_pkg::ndc_state_t state_next;
  logic                resp_reg;
  logic                no_chain_reg;
  logic                prev_fc_reg;
  logic [2:0]          flags_reg;
  logic [2:0]          flags_next;
  logic [1:0]          rf_sync_reg;
  logic [7:0]          code;

  // ----------------------------------------------------------------------
  // Decode and acceptance
  // ----------------------------------------------------------------------
  wire en     = op_ctrl[`NDC_OP_EN_BIT];
  wire tx_en  = op_ctrl[`NDC_OP_TX_EN_BIT];
  wire rf_on  = rf_sync_reg[1];
  wire idle   = (state_reg == ndc_pkg::NDC_IDLE);
  assign code = link.cmd_code;

  wire blocked = link.cmd_chain & no_chain_reg;
  wire go      = link.cmd_stb & ~blocked;

  wire is_sd  = (code == `NDC_CMD_SET_DEFAULT);
  wire is_clr = (code == `NDC_CMD_CLEAR_A) | (code == `NDC_CMD_CLEAR_B);
  wire is_tx  = (code >= `NDC_CMD_TX_CRC) & (code <= `NDC_CMD_TX_WUPA);
  wire is_fon = (code >= `NDC_CMD_FON_INIT) & (code <= `NDC_CMD_FON_RESP0);
  wire is_gtn = (code == `NDC_CMD_GO_NORMAL);
  wire is_rg  = (code == `NDC_CMD_RESET_GAIN);
  wire is_ra  = (code == `NDC_CMD_ADJ_REG);
  wire is_cal = (code > `NDC_CMD_ADJ_REG) & (code <= `NDC_CMD_PHASE);
  wire is_ta  = (code == `NDC_CMD_TEST_ACCESS);
  wire is_tc  = (code == `NDC_CMD_TEST_CLEAR);

  wire acc_sd  = go & is_sd; // R8
  wire acc_clr = go & is_clr & en & osc_freq_ok; // R12
  wire acc_tx  = go & is_tx & en & tx_en & idle; // R14
  wire acc_fon = go & is_fon & en & osc_freq_ok & osc_amp_ok & idle; // R21
  wire acc_gtn = go & is_gtn & brd_mode & idle; // R6
  wire acc_rg  = go & is_rg & en & idle; // R6
  wire acc_ana = go & en & idle & ((is_ra & ~reg_ext_sel) | is_cal); // R2
  wire acc_ta  = go & is_ta; // R6
  wire acc_tc  = go & is_tc & link.cmd_chain & prev_fc_reg; // R5
  wire acc_nc  = acc_sd | acc_rg | acc_ana;

  // Clear stops a running avoidance unless the auto-response bit keeps it.
  wire keep_ca = auto_response_bit & resp_reg & ~idle & (state_reg != ndc_pkg::NDC_WAIT_ANA); // R11
  wire kill    = acc_sd | (acc_clr & ~keep_ca);

  // ----------------------------------------------------------------------
  // Collision avoidance timing
  // ----------------------------------------------------------------------
  wire [1:0]    slot_n   = (code == `NDC_CMD_FON_RESP0) ? 2'h0
                           : {slot_count_hi, slot_count_lo}; // R19
  wire [TW-1:0] slot_cyc = TW'(slot_n) * TW'(RWF_CYC);
  wire          fon_init = (code == `NDC_CMD_FON_INIT);
  wire [TW-1:0] base_cyc = fon_init ? TW'(IDT_CYC) : TW'(ADT_CYC); // R20
  wire [TW-1:0] guard    = resp_reg ? TW'(ARFG_CYC) : TW'(IRFG_CYC); // R17
  wire          tmr_done;
  wire          watch_ok = (state_reg == ndc_pkg::NDC_CA_WATCH) & tmr_done & ~rf_on;
  wire          watch_bad = (state_reg == ndc_pkg::NDC_CA_WATCH) & rf_on;
  wire          guard_ok = (state_reg == ndc_pkg::NDC_CA_GUARD) & tmr_done;
  wire          ana_ok   = (state_reg == ndc_pkg::NDC_WAIT_ANA) & ana_done;
  wire          tmr_load = acc_fon | watch_ok;
  wire [TW-1:0] tmr_val  = acc_fon ? base_cyc + slot_cyc : guard;

  ndc_timer #(
    .TW       (TW)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .stop     (kill),
    .done     (tmr_done)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ndc_pkg::NDC_IDLE:
      begin
        if (acc_ana)
          state_next = ndc_pkg::NDC_WAIT_ANA; // R3 R4
        else if (acc_fon)
          state_next = ndc_pkg::NDC_CA_WATCH; // R16
      end
      ndc_pkg::NDC_WAIT_ANA:
      begin
        if (ana_done)
          state_next = ndc_pkg::NDC_IDLE;
      end
      ndc_pkg::NDC_CA_WATCH:
      begin
        if (rf_on)
          state_next = ndc_pkg::NDC_IDLE; // R18
        else if (tmr_done)
          state_next = ndc_pkg::NDC_CA_GUARD; // R16
      end
      ndc_pkg::NDC_CA_GUARD:
      begin
        if (tmr_done)
          state_next = ndc_pkg::NDC_IDLE; // R17
      end
    endcase
    if (kill)
      state_next = ndc_pkg::NDC_IDLE; // R9
  end

  // Flags: a set in the same cycle as a clear wins.
  wire [2:0] flag_set = {watch_bad, guard_ok, ana_ok}; // R2 R3 R4 R17 R18
  wire [2:0] flag_clr = link.irq_ack | {3{acc_clr | acc_sd}}; // R9
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg    <= ndc_pkg::NDC_IDLE;
      resp_reg     <= 1'b0;
      no_chain_reg <= 1'b0;
      prev_fc_reg  <= 1'b0;
      flags_reg    <= `NDC_IRQ_RESET;
      rf_sync_reg  <= 2'h0;
    end
    else
    begin
      state_reg   <= state_next;
      flags_reg   <= flags_next;
      rf_sync_reg <= {rf_sync_reg[0], rf_sense_inputs};
      if (acc_fon)
        resp_reg <= ~fon_init;
      if (link.cmd_stb)
      begin
        no_chain_reg <= acc_nc;
        prev_fc_reg  <= acc_ta; // R5
      end
    end
  end

  // ----------------------------------------------------------------------
  // Action outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gain_reset_stb  <= 1'b0;
      ana_start_stb   <= 1'b0;
      ana_sel         <= ndc_pkg::NDC_ANA_ANT;
      set_default_stb <= 1'b0;
      fifo_reset_stb  <= 1'b0;
      abort_stb       <= 1'b0;
      timers_stop_stb <= 1'b0;
      nrt_stop_stb    <= 1'b0;
      tx_start_stb    <= 1'b0;
      tx_kind         <= ndc_pkg::NDC_TX_CRC;
      field_on_stb    <= 1'b0;
      leave_brd_stb   <= 1'b0;
      bitrate_def     <= 2'h0;
      tx_modulation_type_bit <= 1'b0;
      test_unlock     <= 1'b0;
      test_clear_stb  <= 1'b0;
    end
    else
    begin
      gain_reset_stb  <= acc_rg; // R1
      ana_start_stb   <= acc_ana; // R2 R3 R4
      set_default_stb <= acc_sd; // R7
      fifo_reset_stb  <= acc_clr | (acc_sd & en); // R8 R9
      abort_stb       <= acc_clr; // R9
      timers_stop_stb <= acc_clr; // R9
      nrt_stop_stb    <= acc_clr & ~nrt_special; // R10
      tx_start_stb    <= acc_tx; // R14
      field_on_stb    <= watch_ok; // R16
      leave_brd_stb   <= acc_gtn; // R22
      test_clear_stb  <= acc_tc; // R5
      if (acc_ana)
        ana_sel <= ndc_pkg::ndc_ana_t'(code[1:0]);
      if (acc_tx)
        tx_kind <= ndc_pkg::ndc_tx_kind_t'(code[1:0]);
      if (acc_gtn)
      begin
        bitrate_def            <= brd_rate; // R22
        tx_modulation_type_bit <= (brd_rate != 2'h0); // R22
      end
      if (acc_ta)
        test_unlock <= 1'b1;
      else if (acc_sd)
        test_unlock <= 1'b0;
    end
  end

  // Codes not decoded above fall through every accept term untouched. R23
  assign link.busy      = ~idle;
  assign link.irq_flags = flags_reg;
  assign link.irq       = |flags_reg;
endmodule : ndc_device

// [rtl/ndc_host.sv]
// Controller end: turns software register writes into command bytes.
`timescale 1ns/100ps
`include "ndc_defines.svh"
module ndc_host (
  input  logic       sys_clk,   // System clock, 40 MHz.
  input  logic       rst,       // Synchronous reset.
  ndc_if.host        link,      // Command link to the device.
  input  logic [1:0] sw_addr,   // Register address.
  input  logic [7:0] sw_wdata,  // Write data.
  input  logic       sw_wr,     // Write strobe.
  input  logic       sw_rd,     // Read strobe.
  output logic [7:0] sw_rdata,  // Read data, cycle after the strobe.
  output logic       sw_irq     // Device interrupt pending.
);
  logic       stb_reg;
  logic       chain_reg;
  logic [7:0] code_reg;
  logic [2:0] ack_reg;
  logic [7:0] rdata_reg;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Software orders the bytes; a write to the chained slot continues a
  // sequence, which is how test access and test clear are paired.
  wire       wr_cmd  = sw_wr & (sw_addr == `NDC_HOST_CMD);
  wire       wr_ch   = sw_wr & (sw_addr == `NDC_HOST_CMD_CH); // R5
  wire       rd_stat = sw_rd & (sw_addr == `NDC_HOST_STATUS);
  wire [7:0] status  = {4'h0, link.busy, link.irq_flags}; // R18
  wire [7:0] rmux    = rd_stat ? status : 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stb_reg   <= 1'b0;
      chain_reg <= 1'b0;
      code_reg  <= 8'h00;
      ack_reg   <= 3'h0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      stb_reg   <= wr_cmd | wr_ch;
      chain_reg <= wr_ch;
      if (wr_cmd | wr_ch)
        code_reg <= sw_wdata;
      ack_reg   <= rd_stat ? link.irq_flags : 3'h0;
      rdata_reg <= sw_rd ? rmux : 8'h00;
    end
  end

  assign link.cmd_stb   = stb_reg;
  assign link.cmd_chain = chain_reg;
  assign link.cmd_code  = code_reg;
  assign link.irq_ack   = ack_reg;
  assign sw_rdata       = rdata_reg;
  assign sw_irq         = link.irq;
endmodule : ndc_host

// [tb/ndc_monitor.sv]
// Checker for the command link between the controller and the device.
`timescale 1ns/100ps
`include "ndc_defines.svh"
module ndc_monitor #(
  parameter int IDT_CYC  = 12083,
  parameter int IRFG_CYC = 200001
) (
  input logic       sys_clk,   // System clock.
  input logic       rst,       // Synchronous reset.
  input logic       cmd_stb,   // Command byte strobe.
  input logic       cmd_chain, // Chained byte.
  input logic [7:0] cmd_code,  // Command byte.
  input logic       busy,      // Device sequence running.
  input logic       irq,       // Interrupt line.
  input logic [2:0] irq_flags, // Sticky flags.
  input logic [2:0] irq_ack    // Flag clear pulse.
);
  localparam int GSUM = IDT_CYC + IRFG_CYC;
  localparam int GMIN = (GSUM < 5287 ? GSUM : 5287) - 4;
  logic [17:0] busy_cnt;

  // Counts busy cycles, so the guard wait before the field flag can be bounded.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !busy)
      busy_cnt <= '0;
    else if (busy_cnt != '1)
      busy_cnt <= busy_cnt + 1'b1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_setdef;
    cmd_stb && !cmd_chain && cmd_code == `NDC_CMD_SET_DEFAULT;
  endsequence
  property p_irq_or;
    irq == (|irq_flags);
  endproperty
  property p_setdef_idle;
    s_setdef |=> !busy;
  endproperty
  property p_setdef_flags;
    s_setdef ##0 !busy |=> irq_flags == 3'h0;
  endproperty
  property p_flag_src;
    (|(irq_flags & ~$past(irq_flags))) |-> $past(busy);
  endproperty
  property p_ack_clear;
    (irq_ack != 3'h0 && !busy) |=> (irq_flags & $past(irq_ack)) == 3'h0;
  endproperty
  property p_ack_subset;
    irq_ack != 3'h0 |-> (irq_ack & ~$past(irq_flags)) == 3'h0;
  endproperty
  property p_busy_cause;
    $rose(busy) |-> $past(cmd_stb) && ($past(cmd_code) inside
      {8'hc8, 8'hc9, 8'hca, 8'hd6, 8'hd7, 8'hd8, 8'hd9});
  endproperty
  property p_unused;
    cmd_stb && !busy && (cmd_code inside {[8'h00:8'hc0], [8'hcc:8'hd4],
      [8'hda:8'hf9], 8'hfb, [8'hfd:8'hff]}) |=> !busy;
  endproperty
  property p_guard;
    $rose(irq_flags[1]) |-> $past(busy_cnt) >= GMIN;
  endproperty

  a_irq_or: assert property (p_irq_or)
    else $error("irq differs from the flag OR");
  a_setdef_idle: assert property (p_setdef_idle)
    else $error("busy after set default");
  a_setdef_flags: assert property (p_setdef_flags)
    else $error("flags kept after set default");
  a_flag_src: assert property (p_flag_src)
    else $error("flag raised without a running sequence");
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledged flag not cleared");
  a_ack_subset: assert property (p_ack_subset)
    else $error("acknowledge of a flag that was not set");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without a sequence command");
  a_unused: assert property (p_unused)
    else $error("unused code started a sequence");
  a_guard: assert property (p_guard)
    else $error("field flag before the guard time");
endmodule : ndc_monitor

// [tb/tb_top.sv]
// Testbench: software writes commands through the controller to the device.
`timescale 1ns/100ps
`include "ndc_defines.svh"
module tb_top;
  localparam logic [7:0] BAD [5] = '{8'hcc, 8'hd2, 8'hdb, 8'he1, 8'hfb};
  localparam logic [1:0] SEL [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, op_ctrl;
  logic sw_wr, sw_rd, sw_irq, clr, osc_freq_ok, osc_amp_ok, reg_ext_sel, nrt_special;
  logic auto_response_bit, slot_count_hi, slot_count_lo, rf_sense_inputs, brd_mode, ana_done;
  logic [1:0] brd_rate, bitrate_def;
  logic gain_reset_stb, ana_start_stb, set_default_stb, fifo_reset_stb, abort_stb;
  logic timers_stop_stb, nrt_stop_stb, tx_start_stb, field_on_stb, leave_brd_stb;
  logic test_clear_stb, tx_modulation_type_bit, test_unlock;
  ndc_pkg::ndc_ana_t ana_sel;
  ndc_pkg::ndc_tx_kind_t tx_kind;
  logic [10:0] seen = '0;
  int err_total = 0;
  int compares = 0;
  int i;
  wire [10:0] stb_v = {gain_reset_stb, ana_start_stb, set_default_stb, fifo_reset_stb,
    abort_stb, timers_stop_stb, nrt_stop_stb, tx_start_stb, field_on_stb, leave_brd_stb,
    test_clear_stb};

  ndc_if i_ndc_if ();
  ndc_host i_ndc_host (.sys_clk(sys_clk), .rst(rst), .link(i_ndc_if), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sw_irq(sw_irq));
  ndc_device #(.IDT_CYC(40), .IRFG_CYC(60)) i_ndc_device (.sys_clk(sys_clk), .rst(rst),
    .link(i_ndc_if), .op_ctrl(op_ctrl), .osc_freq_ok(osc_freq_ok), .osc_amp_ok(osc_amp_ok),
    .reg_ext_sel(reg_ext_sel), .nrt_special(nrt_special),
    .auto_response_bit(auto_response_bit), .slot_count_hi(slot_count_hi),
    .slot_count_lo(slot_count_lo), .rf_sense_inputs(rf_sense_inputs), .brd_mode(brd_mode),
    .brd_rate(brd_rate), .ana_done(ana_done), .gain_reset_stb(gain_reset_stb),
    .ana_start_stb(ana_start_stb), .ana_sel(ana_sel), .set_default_stb(set_default_stb),
    .fifo_reset_stb(fifo_reset_stb), .abort_stb(abort_stb),
    .timers_stop_stb(timers_stop_stb), .nrt_stop_stb(nrt_stop_stb),
    .tx_start_stb(tx_start_stb), .tx_kind(tx_kind), .field_on_stb(field_on_stb),
    .leave_brd_stb(leave_brd_stb), .bitrate_def(bitrate_def),
    .tx_modulation_type_bit(tx_modulation_type_bit), .test_unlock(test_unlock),
    .test_clear_stb(test_clear_stb));
  ndc_monitor #(.IDT_CYC(40), .IRFG_CYC(60)) i_ndc_monitor (.sys_clk(sys_clk), .rst(rst),
    .cmd_stb(i_ndc_if.cmd_stb), .cmd_chain(i_ndc_if.cmd_chain),
    .cmd_code(i_ndc_if.cmd_code), .busy(i_ndc_if.busy), .irq(i_ndc_if.irq),
    .irq_flags(i_ndc_if.irq_flags), .irq_ack(i_ndc_if.irq_ack));
  always #12.5 sys_clk = ~sys_clk;

  // Collects every strobe pulse since the last command write.
  always @(posedge sys_clk)
    seen <= clr ? 11'h0 : seen | stb_v;

  // ----------------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------------
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    clr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    clr <= 1'b0;
  endtask : wr

  task automatic stat(input logic [1:0] a, input logic [7:0] e);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1;
    chk("status", 11'(e), 11'(sw_rdata));
    @(posedge sys_clk);
  endtask : stat

  task automatic cmd(input logic [7:0] c, input logic ch, input logic [10:0] e);
    wr({1'b0, ch}, c);
    repeat (4) @(posedge sys_clk);
    chk("strobes", e, seen);
  endtask : cmd

  task automatic fon(input int w);
    int n;
    n = 0;
    while (!seen[2] && n < w + 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("field delay", 11'h1, 11'(n >= w - 16 && n <= w));
    if (!seen[2])
      conclude();
  endtask : fon

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {sw_addr, sw_wdata, sw_wr, sw_rd, clr, reg_ext_sel, nrt_special} = '0;
    {auto_response_bit, slot_count_hi, slot_count_lo, rf_sense_inputs} = '0;
    {brd_mode, brd_rate, ana_done, op_ctrl} = '0;
    {osc_freq_ok, osc_amp_ok} = 2'b11;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmd(`NDC_CMD_RESET_GAIN, 1'b0, 11'h0);
    op_ctrl <= 8'h80;
    cmd(`NDC_CMD_TX_CRC, 1'b0, 11'h0);
    cmd(`NDC_CMD_RESET_GAIN, 1'b0, 11'h400);
    cmd(`NDC_CMD_RESET_GAIN, 1'b1, 11'h0);
    op_ctrl <= 8'h88;
    cmd(`NDC_CMD_CLEAR_A, 1'b0, 11'h0f0);
    for (i = 0; i < 4; i++)
    begin
      cmd(8'(8'hc4 + i), 1'b0, 11'h008);
      chk("tx_kind", 11'(i), 11'(tx_kind));
    end
    osc_freq_ok <= 1'b0;
    cmd(`NDC_CMD_CLEAR_A, 1'b0, 11'h0);
    osc_freq_ok <= 1'b1;
    cmd(`NDC_CMD_CLEAR_A, 1'b0, 11'h0f0);
    nrt_special <= 1'b1;
    cmd(`NDC_CMD_CLEAR_B, 1'b1, 11'h0e0);
    op_ctrl <= 8'h08;
    cmd(`NDC_CMD_SET_DEFAULT, 1'b0, 11'h100);
    op_ctrl <= 8'h88;
    cmd(`NDC_CMD_SET_DEFAULT, 1'b0, 11'h180);
    cmd(`NDC_CMD_TX_CRC, 1'b1, 11'h0);
    cmd(`NDC_CMD_TEST_CLEAR, 1'b1, 11'h0);
    cmd(`NDC_CMD_TEST_ACCESS, 1'b0, 11'h0);
    chk("test_unlock", 11'h1, 11'(test_unlock));
    cmd(`NDC_CMD_TEST_CLEAR, 1'b1, 11'h001);
    cmd(`NDC_CMD_SET_DEFAULT, 1'b0, 11'h180);
    chk("test_unlock", 11'h0, 11'(test_unlock));
    for (i = 0; i < 5; i++)
      cmd(BAD[i], 1'b0, 11'h0);
    cmd(`NDC_CMD_GO_NORMAL, 1'b0, 11'h0);
    brd_mode <= 1'b1;
    brd_rate <= 2'h2;
    cmd(`NDC_CMD_GO_NORMAL, 1'b0, 11'h002);
    chk("bitrate_def", 11'h2, 11'(bitrate_def));
    chk("tx_modulation_type_bit", 11'h1, 11'(tx_modulation_type_bit));
    reg_ext_sel <= 1'b1;
    cmd(`NDC_CMD_ADJ_REG, 1'b0, 11'h0);
    reg_ext_sel <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      cmd(8'(8'hd6 + i), 1'b0, 11'h200);
      chk("ana_sel", 11'(SEL[i]), 11'(ana_sel));
      stat(2'h2, 8'h08);
      ana_done <= 1'b1;
      @(posedge sys_clk);
      ana_done <= 1'b0;
      repeat (3) @(posedge sys_clk);
      stat(2'h2, 8'h01);
      stat(2'h2, 8'h00);
    end
    wr(2'h2, `NDC_CMD_FON_INIT);
    stat(2'h3, 8'h00);
    osc_amp_ok <= 1'b0;
    cmd(`NDC_CMD_FON_INIT, 1'b0, 11'h0);
    stat(2'h2, 8'h00);
    osc_amp_ok <= 1'b1;
    slot_count_lo <= 1'b1;
    cmd(`NDC_CMD_FON_INIT, 1'b0, 11'h0);
    fon(40 + 1511);
    stat(2'h2, 8'h08);
    repeat (45) @(posedge sys_clk);
    stat(2'h2, 8'h08);
    repeat (20) @(posedge sys_clk);
    chk("sw_irq", 11'h1, 11'(sw_irq));
    stat(2'h2, 8'h02);
    slot_count_hi <= 1'b1;
    cmd(`NDC_CMD_FON_RESP0, 1'b0, 11'h0);
    fon(2266);
    repeat (3100) @(posedge sys_clk);
    stat(2'h2, 8'h02);
    slot_count_lo <= 1'b0;
    cmd(`NDC_CMD_FON_RESP, 1'b0, 11'h0);
    fon(2266 + 2 * 1511);
    repeat (3100) @(posedge sys_clk);
    stat(2'h2, 8'h02);
    {slot_count_hi, rf_sense_inputs} <= 2'b01;
    cmd(`NDC_CMD_FON_RESP, 1'b0, 11'h0);
    repeat (2400) @(posedge sys_clk);
    chk("strobes", 11'h0, seen);
    stat(2'h2, 8'h04);
    {rf_sense_inputs, auto_response_bit} <= 2'b01;
    cmd(`NDC_CMD_FON_RESP, 1'b0, 11'h0);
    cmd(`NDC_CMD_CLEAR_A, 1'b1, 11'h0e0);
    fon(2266);
    repeat (3100) @(posedge sys_clk);
    stat(2'h2, 8'h02);
    auto_response_bit <= 1'b0;
    cmd(`NDC_CMD_FON_RESP, 1'b0, 11'h0);
    cmd(`NDC_CMD_CLEAR_A, 1'b0, 11'h0e0);
    stat(2'h2, 8'h00);
    conclude();
  end
endmodule : tb_top
